// ---- core/cr8_core.sv ----
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module cr8_core
  import cr8_pkg::*;
#(
  parameter int PM_DEPTH = 1024,
  parameter int STK_DEPTH = 8
)
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata
);
  localparam int PMA = $clog2(PM_DEPTH);
  localparam int SPW = $clog2(STK_DEPTH);

  logic [IW-1:0]  pm [PM_DEPTH];
  logic [DW-1:0]  dmem [256];
  logic [PCW-1:0] stk [STK_DEPTH];
  logic [IW-1:0]  ir;
  logic           ir_valid;
  logic [PCW-1:0] pc;
  logic [DW-1:0]  w;
  logic [DW-1:0]  status;
  logic [DW-1:0]  fsr;
  logic [4:0]     pclath;
  logic [SPW-1:0] sp;
  logic           run;
  logic           restart;
  logic [PMA-1:0] pm_addr;
  logic           wr_pend;
  logic [7:0]     wr_addr;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  wire ap_take = hsel && hready && htrans[1];
  wire [7:0] ap_off = haddr[7:0];
  wire wr_ctrl = wr_pend && wr_addr == R_CTRL;
  wire wr_pma = wr_pend && wr_addr == R_PMADDR;
  wire wr_pmd = wr_pend && wr_addr == R_PMDATA;
  wire [31:0] st_word = {{(32-SF_PC-PCW){1'b0}}, pc, status, w};
  wire [31:0] rd_mux =
    (ap_off == R_CTRL)   ? {30'h0, 1'b0, run} :
    (ap_off == R_PMADDR) ? {{(32-PMA){1'b0}}, pm_addr} :
    (ap_off == R_PMDATA) ? {{(32-IW){1'b0}}, pm[pm_addr]} :
    (ap_off == R_STATE)  ? st_word : 32'h0;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0;
    end
    else
    begin
      wr_pend <= ap_take && hwrite;
      wr_addr <= ap_off;
      if (ap_take && !hwrite)
        hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      run <= 1'b0;
      restart <= 1'b0;
      pm_addr <= '0;
    end
    else
    begin
      restart <= wr_ctrl && hwdata[CTRL_RESTART];
      if (wr_ctrl)
        run <= hwdata[CTRL_RUN];
      if (wr_pma)
        pm_addr <= hwdata[PMA-1:0];
      else if (wr_pmd)
        pm_addr <= pm_addr + 1'b1;
    end
  end

  // Program store written word by word; address auto-advances
  always_ff @(posedge hclk)
  begin
    if (wr_pmd)
      pm[pm_addr] <= hwdata[IW-1:0];
  end

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire       exec = run && ir_valid;
  wire [6:0] f_fld = ir[6:0];
  wire       dst_f = ir[7];
  wire [7:0] lit = ir[7:0];
  wire [2:0] bit_no = ir[9:7];
  // Indirect slot redirects through the pointer register
  wire [7:0] ea = (f_fld == A_INDF) ? fsr : {status[ST_RP0], f_fld};
  wire [IW-1:0] fetch_word = pm[pc[PMA-1:0]];
  cr8_op_t op;

  always_comb
  begin
    op = OP_NOP;
    unique case (ir[13:12])
      2'h0:
        unique case (ir[11:8])
          4'h0: op = dst_f ? OP_MOVWF :
                     (ir[6:0] == 7'h08) ? OP_RETURN : OP_NOP;
          4'h1: op = OP_CLR;
          4'h2: op = OP_SUBWF;
          4'h3: op = OP_DECF;
          4'h4: op = OP_IORWF;
          4'h5: op = OP_ANDWF;
          4'h6: op = OP_XORWF;
          4'h7: op = OP_ADDWF;
          4'h8: op = OP_MOVF;
          4'h9: op = OP_COMF;
          4'hA: op = OP_INCF;
          4'hB: op = OP_DECFSZ;
          4'hC: op = OP_RRF;
          4'hD: op = OP_RLF;
          4'hE: op = OP_SWAPF;
          4'hF: op = OP_INCFSZ;
        endcase
      2'h1:
        unique case (ir[11:10])
          2'h0: op = OP_BCF;
          2'h1: op = OP_BSF;
          2'h2: op = OP_BTFSC;
          2'h3: op = OP_BTFSS;
        endcase
      2'h2: op = ir[11] ? OP_GOTO : OP_CALL;
      2'h3:
        casez (ir[11:8])
          4'b00??: op = OP_MOVLW;
          4'b01??: op = OP_RETLW;
          4'h8:    op = OP_IORLW;
          4'h9:    op = OP_ANDLW;
          4'hA:    op = OP_XORLW;
          4'b110?: op = OP_SUBLW;
          4'b111?: op = OP_ADDLW;
          default: op = OP_NOP;
        endcase
    endcase
  end

  // ---------------------------------------------------------------
  // Operand fetch
  // ---------------------------------------------------------------
  logic [7:0] fval;
  always_comb
  begin
    unique case (ea[6:0])
      A_INDF:   fval = 8'h00;
      A_PCL:    fval = pc[7:0];
      A_STATUS: fval = status;
      A_FSR:    fval = fsr;
      A_PCLATH: fval = {3'h0, pclath};
      default:  fval = dmem[ea];
    endcase
  end

  // ---------------------------------------------------------------
  // ALU
  // ---------------------------------------------------------------
  wire is_sub = (op == OP_SUBWF) || (op == OP_SUBLW);
  wire lit_op = (ir[13:12] == 2'h3);
  wire [7:0] opnd = lit_op ? lit : fval;
  // Subtract as opnd + ~w + 1 so the carry out is a not-borrow
  wire [7:0] add_b = is_sub ? ~w : w;
  wire [8:0] sum = {1'b0, opnd} + {1'b0, add_b} + {8'h00, is_sub};
  wire [4:0] nsum = {1'b0, opnd[3:0]} + {1'b0, add_b[3:0]}
                  + {4'h0, is_sub};
  wire [7:0] bmask = 8'h01 << bit_no;

  logic [7:0] res;
  logic       upd_z;
  logic       upd_cdc;
  logic       upd_c;
  logic       c_new;
  logic       wr_w;
  logic       wr_f;
  always_comb
  begin
    res = fval;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    upd_c = 1'b0;
    c_new = sum[8];
    wr_w = 1'b0;
    wr_f = 1'b0;
    unique case (op)
      OP_MOVWF: begin res = w; wr_f = 1'b1; end
      OP_CLR: begin res = 8'h00; upd_z = 1'b1; end
      OP_SUBWF, OP_ADDWF, OP_SUBLW, OP_ADDLW:
      begin
        res = sum[7:0];
        upd_z = 1'b1;
        upd_cdc = 1'b1;
      end
      OP_DECF, OP_DECFSZ: res = fval - 8'h01;
      OP_INCF, OP_INCFSZ: res = fval + 8'h01;
      OP_IORWF, OP_IORLW: begin res = opnd | w; upd_z = 1'b1; end
      OP_ANDWF, OP_ANDLW: begin res = opnd & w; upd_z = 1'b1; end
      OP_XORWF, OP_XORLW: begin res = opnd ^ w; upd_z = 1'b1; end
      OP_MOVF: upd_z = 1'b1;
      OP_COMF: begin res = ~fval; upd_z = 1'b1; end
      OP_RRF:
      begin
        res = {status[ST_C], fval[7:1]};
        c_new = fval[0];
        upd_c = 1'b1;
      end
      OP_RLF:
      begin
        res = {fval[6:0], status[ST_C]};
        c_new = fval[7];
        upd_c = 1'b1;
      end
      OP_SWAPF: res = {fval[3:0], fval[7:4]};
      OP_BCF: begin res = fval & ~bmask; wr_f = 1'b1; end
      OP_BSF: begin res = fval | bmask; wr_f = 1'b1; end
      OP_MOVLW, OP_RETLW: res = lit;
      default: res = fval;
    endcase
    if (op == OP_DECF || op == OP_INCF)
      upd_z = 1'b1;
    // The d bit picks the accumulator or the file as destination
    if (!lit_op && ir[13:12] == 2'h0 && op != OP_MOVWF && op != OP_NOP
        && op != OP_RETURN)
    begin
      wr_f = dst_f;
      wr_w = !dst_f;
    end
    if (lit_op)
      wr_w = 1'b1;
  end

  // ---------------------------------------------------------------
  // Flow control
  // ---------------------------------------------------------------
  wire bit_set = |(fval & bmask);
  wire skip = ((op == OP_BTFSC) && !bit_set) ||
              ((op == OP_BTFSS) && bit_set) ||
              ((op == OP_DECFSZ || op == OP_INCFSZ) && res == 8'h00);
  wire pcl_wr = wr_f && ea[6:0] == A_PCL;
  wire jump = (op == OP_GOTO) || (op == OP_CALL);
  wire ret = (op == OP_RETURN) || (op == OP_RETLW);
  // Any flow change discards the word fetched alongside it
  wire flush = exec && (jump || ret || skip || pcl_wr);
  wire [SPW-1:0] sp_dec = sp - 1'b1;
  logic [PCW-1:0] next_pc;
  always_comb
  begin
    next_pc = pc + 1'b1;
    if (exec && jump)
      next_pc = {pclath[4:3], ir[10:0]};
    else if (exec && ret)
      next_pc = stk[sp_dec];
    else if (exec && pcl_wr)
      next_pc = {pclath, res};
  end

  wire [7:0] next_status_base = (wr_f && ea[6:0] == A_STATUS) ?
                                {res[7:5], status[4:3], res[2:0]} : status;
  logic [7:0] next_status;
  always_comb
  begin
    next_status = next_status_base;
    if (upd_z)
      next_status[ST_Z] = (res == 8'h00);
    if (upd_cdc)
    begin
      next_status[ST_C] = sum[8];
      next_status[ST_NIBBLE] = nsum[4];
    end
    if (upd_c)
      next_status[ST_C] = c_new;
  end

  // ---------------------------------------------------------------
  // Pipeline and architectural state
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ir <= '0;
      ir_valid <= 1'b0;
      pc <= '0;
      sp <= '0;
    end
    else if (restart)
    begin
      ir_valid <= 1'b0;
      pc <= '0;
      sp <= '0;
    end
    else if (run)
    begin
      ir <= fetch_word;
      ir_valid <= !flush;
      pc <= next_pc;
      if (exec && op == OP_CALL)
        sp <= sp + 1'b1;
      else if (exec && ret)
        sp <= sp_dec;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      w <= 8'h00;
      status <= STATUS_RST;
      fsr <= 8'h00;
      pclath <= 5'h00;
    end
    else if (exec && !restart)
    begin
      if (wr_w)
        w <= res;
      status <= next_status;
      if (wr_f && ea[6:0] == A_FSR)
        fsr <= res;
      if (wr_f && ea[6:0] == A_PCLATH)
        pclath <= res[4:0];
    end
  end

  // Return stack wraps silently when nesting runs too deep
  always_ff @(posedge hclk)
  begin
    if (exec && op == OP_CALL && !restart)
      stk[sp] <= pc;
  end

  // Plain file locations; special slots live in their own flops
  wire sfr_hit = ea[6:0] == A_INDF || ea[6:0] == A_PCL ||
                 ea[6:0] == A_STATUS || ea[6:0] == A_FSR ||
                 ea[6:0] == A_PCLATH;
  always_ff @(posedge hclk)
  begin
    if (exec && wr_f && !sfr_hit && !restart)
      dmem[ea] <= res;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  wire live = exec && !restart;

  a_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    live && upd_z && !(wr_f && ea[6:0] == A_STATUS)
    |=> status[ST_Z] == ($past(res) == 8'h00))
    else $error("zero flag wrong");

  a_borrow_low: assert property (@(posedge hclk) disable iff (!hresetn)
    live && is_sub && !(wr_f && ea[6:0] == A_STATUS)
    |=> status[ST_C] == ($past(opnd) >= $past(w)))
    else $error("carry not an active-low borrow");

  a_nibble_borrow: assert property (@(posedge hclk) disable iff (!hresetn)
    live && is_sub && !(wr_f && ea[6:0] == A_STATUS)
    |=> status[ST_NIBBLE] == ($past(opnd[3:0]) >= $past(w[3:0])))
    else $error("nibble carry not a borrow");

  a_flow_refill: assert property (@(posedge hclk) disable iff (!hresetn)
    live && (jump || ret) |=> !ir_valid ##1 (ir_valid || !run))
    else $error("pipeline not refilled after flow change");

  a_fetch_overlap: assert property (@(posedge hclk) disable iff (!hresetn)
    run && !restart && !flush |=> ir_valid && ir == $past(fetch_word))
    else $error("fetch did not overlap execute");

  a_pc_step: assert property (@(posedge hclk) disable iff (!hresetn)
    live && !flush |=> pc == $past(pc) + 1'b1)
    else $error("single-cycle instruction did not advance pc");

  a_acc_write: assert property (@(posedge hclk) disable iff (!hresetn)
    live && wr_w |=> w == $past(res))
    else $error("accumulator not written");

  a_file_write: assert property (@(posedge hclk) disable iff (!hresetn)
    live && wr_f && !sfr_hit |=> dmem[$past(ea)] == $past(res))
    else $error("file register not written");

  c_subtract: cover property (@(posedge hclk) live && is_sub);
  c_call_return: cover property (@(posedge hclk)
    live && op == OP_CALL ##[1:20] live && ret);
  c_skip: cover property (@(posedge hclk) live && skip);
  c_indirect: cover property (@(posedge hclk)
    live && wr_f && f_fld == A_INDF);
endmodule

// ---- core/cr8_pkg.sv ----
// What this block does
// - Each instruction is a single 14-bit word in one program location.
// - Instructions arrive over their own 14-bit bus, one whole per cycle.
// - Fetch of the next instruction overlaps execution of the current.
// - All 31 decoded operations but flow changes take one cycle; flow changes take two to refill the pipe.
// - Program memory is internal, 512, 1K or 2K words of 14 bits.
// - Special registers, the program counter too, sit in data space.
// - Any operation works on any register by any addressing mode.
// - The 8-bit ALU adds, subtracts, shifts and does logic, two's complement.
// - Two-operand operations pair the accumulator with a file or literal.
// - One-operand operations act on the accumulator or a file register.
// - The 8-bit accumulator feeds the ALU and has no data address.
// - Instructions update carry, nibble carry and zero as they define.
// - In subtraction carry and nibble carry act as borrow indications.
// - Special registers are static storage inside data space.
package cr8_pkg;
  // ---------------------------------------------------------------
  // Core widths and special register map
  // ---------------------------------------------------------------
  localparam int DW = 8;
  localparam int IW = 14;
  localparam int PCW = 13;
  localparam logic [6:0] A_INDF = 7'h00;
  localparam logic [6:0] A_PCL = 7'h02;
  localparam logic [6:0] A_STATUS = 7'h03;
  localparam logic [6:0] A_FSR = 7'h04;
  localparam logic [6:0] A_PCLATH = 7'h0A;
  localparam int ST_C = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_Z = 2;
  localparam int ST_RP0 = 5;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // ---------------------------------------------------------------
  // Bus register map
  // ---------------------------------------------------------------
  localparam logic [7:0] R_CTRL = 8'h00;
  localparam logic [7:0] R_PMADDR = 8'h04;
  localparam logic [7:0] R_PMDATA = 8'h08;
  localparam logic [7:0] R_STATE = 8'h0C;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_RESTART = 1;
  localparam int SF_W = 0;
  localparam int SF_ST = 8;
  localparam int SF_PC = 16;
  typedef enum logic [4:0] {
    OP_NOP, OP_RETURN, OP_MOVWF, OP_CLR, OP_SUBWF, OP_DECF, OP_IORWF,
    OP_ANDWF, OP_XORWF, OP_ADDWF, OP_MOVF, OP_COMF, OP_INCF, OP_DECFSZ,
    OP_RRF, OP_RLF, OP_SWAPF, OP_INCFSZ, OP_BCF, OP_BSF, OP_BTFSC,
    OP_BTFSS, OP_CALL, OP_GOTO, OP_MOVLW, OP_RETLW, OP_IORLW, OP_ANDLW,
    OP_XORLW, OP_SUBLW, OP_ADDLW
  } cr8_op_t;
endpackage

// ---- verif/cr8_bus_master.sv ----
`timescale 1ns/1ps
module cr8_bus_master
(
  input  wire logic        hclk,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ---------------------------------------------------------------
  // Single word transfer
  // ---------------------------------------------------------------
  // Bounded waits; ok stays low when the slave never answers
  task automatic xfer(
    input  logic        wr,
    input  logic [7:0]  a,
    input  logic [31:0] wd,
    output logic [31:0] rd,
    output logic        ok
  );
    int n;
    ok = 1'b0;
    rd = 32'h0;
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    // Stale write data is scrambled so it never looks valid
    hwdata <= ~hwdata;
    for (n = 0; n < 16; n++)
    begin
      @(posedge hclk);
      if (hready === 1'b1)
        break;
    end
    if (n == 16)
      return;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    for (n = 0; n < 16; n++)
    begin
      @(posedge hclk);
      if (hready === 1'b1)
        break;
    end
    if (n == 16)
      return;
    rd = hrdata;
    ok = 1'b1;
  endtask
endmodule

// ---- verif/cr8_core_test.sv ----
`timescale 1ns/1ps
module cr8_core_test;
  import cr8_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  int          miscompares;
  int          num_checks;

  cr8_core #(.PM_DEPTH(512), .STK_DEPTH(8)) cr8_core_inst (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata)
  );

  cr8_bus_master cr8_bus_master_inst (
    .hclk   (hclk),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hwdata (hwdata),
    .hready (hreadyout),
    .hrdata (hrdata)
  );

  always #2.5 hclk = ~hclk;

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic complete_run;
    if (miscompares == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    logic ok;
    cr8_bus_master_inst.xfer(wr, a, wd, rd, ok);
    if (ok !== 1'b1)
    begin
      miscompares++;
      complete_run();
    end
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, a, d, rd);
  endtask

  task automatic rd32(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask

  // Loads a program that parks in a jump to itself, then checks W/flags
  task automatic run_prog(input logic [13:0] prog[$],
                          input logic [15:0] exp);
    logic [31:0] st;
    wr32(R_CTRL, 32'h0);
    wr32(R_PMADDR, 32'h0);
    foreach (prog[i])
      wr32(R_PMDATA, {18'h0, prog[i]});
    wr32(R_CTRL, 32'h2);
    wr32(R_CTRL, 32'h1);
    repeat (40) @(posedge hclk);
    wr32(R_CTRL, 32'h0);
    rd32(R_STATE, st);
    check("state", st & 32'h0000_FFFF, {16'h0, exp});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic s_reset;
    logic [31:0] d;
    rd32(R_STATE, d);
    check("reset state", d, 32'h0000_1800);
    rd32(8'h10, d);
    check("unmapped", d, 32'h0);
    check("hreadyout", {31'h0, hreadyout}, 32'h1);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic s_prog_store;
    logic [31:0] d;
    wr32(R_PMADDR, 32'hFFFF_FFFF);
    rd32(R_PMADDR, d);
    check("pm index top", d, 32'h0000_01FF);
    wr32(R_PMDATA, 32'hFFFF_FFFF);
    rd32(R_PMADDR, d);
    check("pm index wrap", d, 32'h0);
    wr32(R_PMADDR, 32'h0000_01FF);
    rd32(R_PMDATA, d);
    check("pm word", d, 32'h0000_3FFF);
  endtask

  task automatic s_add_flags;
    run_prog('{14'h30FF, 14'h3E01, 14'h2802}, 16'h1F00);
  endtask

  task automatic s_sub_flags;
    run_prog('{14'h3005, 14'h3C07, 14'h2802}, 16'h1B02);
    run_prog('{14'h3001, 14'h3C00, 14'h2802}, 16'h18FF);
  endtask

  task automatic s_file_ops;
    run_prog('{14'h3021, 14'h00A0, 14'h300F, 14'h0720,
               14'h2804}, 16'h1A30);
    run_prog('{14'h3080, 14'h00A0, 14'h0920, 14'h2803},
             16'h1A7F);
    run_prog('{14'h305A, 14'h3A5A, 14'h2802}, 16'h1E00);
  endtask

  // Write to the counter low byte must skip the word already fetched
  task automatic s_jump;
    run_prog('{14'h3004, 14'h0082, 14'h3011, 14'h2803, 14'h305A,
               14'h2805}, 16'h1E5A);
  endtask

  // Subroutine hands a literal back in W as it returns through the stack
  task automatic s_call;
    run_prog('{14'h3005, 14'h2004, 14'h3E01, 14'h2803,
               14'h3433}, 16'h1834);
  endtask

  // Bit set through the pointer, rotate into W, then a taken skip
  task automatic s_bit_skip;
    run_prog('{14'h3020, 14'h0084, 14'h01A0, 14'h1580, 14'h0D20,
               14'h1DA0, 14'h3E40, 14'h2807}, 16'h1C10);
  endtask

  initial
  begin
    hclk = 1'b0;
    hresetn = 1'b0;
    miscompares = 0;
    num_checks = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    s_reset();
    s_prog_store();
    s_add_flags();
    s_sub_flags();
    s_file_ops();
    s_jump();
    s_call();
    s_bit_skip();
    complete_run();
  end
endmodule
